// file: pkg/cfg_hdr_pkg.sv
package cfg_hdr_pkg;

  // ==========================================================
  // configuration header byte offsets (function 0)
  localparam logic [8:0] OFS_REV_CLASS = 9'h008;
  localparam logic [8:0] OFS_MISC      = 9'h00C;
  localparam logic [8:0] OFS_BAR_MEM   = 9'h010;
  localparam logic [8:0] OFS_BAR_IO    = 9'h014;
  localparam logic [8:0] OFS_BAR_FLASH = 9'h018;
  localparam logic [8:0] OFS_CIS_PTR   = 9'h028;
  localparam logic [8:0] OFS_BAR_ROM   = 9'h030;
  localparam int         FN_SEL_BIT    = 8;

  // ==========================================================
  // fixed field values
  localparam logic [23:0] CLASS_CODE  = 24'h02_0000;
  localparam logic [7:0]  HDR_SINGLE  = 8'h00;
  localparam logic [7:0]  HDR_COMBO   = 8'h80;
  localparam logic [7:0]  CLS_8_DW    = 8'h08;
  localparam logic [7:0]  CLS_16_DW   = 8'h10;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
  localparam logic [31:0] CIS_PTR_CB  = 32'h0001_0003;

  // ==========================================================
  // window masks: set bits are writable (rom enable bit 0 included), fixed bits give type
  localparam logic [31:0] MEM_MASK    = 32'hFFFF_F000;
  localparam logic [31:0] IO_MASK     = 32'hFFFF_FFC0;
  localparam logic [31:0] FLASH_MASK  = 32'hFFFE_0000;
  localparam logic [31:0] ROM_MASK    = 32'hFFF0_0001;
  localparam logic [31:0] TYPE_MEM    = 32'h0000_0000;
  localparam logic [31:0] TYPE_IO     = 32'h0000_0001;
  localparam int          CIS_OFS_BIT = 16;
  localparam int          ROM_EN_BIT  = 0;

  // ==========================================================
  // eeprom control word fields
  localparam int         EE_SIG_HI     = 15;
  localparam int         EE_SIG_LO     = 14;
  localparam logic [1:0] EE_SIG_OK     = 2'b01;
  localparam int         EE_ID_BIT     = 13;
  localparam int         EE_COMBO_BIT  = 12;
  localparam int         EE_BOOTDIS    = 11;
  localparam int         EE_REV_HI     = 10;
  localparam int         EE_REV_LO     = 8;

endpackage

// file: verilog/window_base_reg.sv
`timescale 1ns/1ns
// one base address register: only masked bits store, fixed bits are constant
module window_base_reg import cfg_hdr_pkg::*; #(
  parameter logic [31:0] WMASK = 32'hFFFF_F000,
  parameter logic [31:0] FIXED = 32'h0000_0000
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        wr_en,
  input  wire logic [3:0]  be,
  input  wire logic [31:0] wdata,
  output logic      [31:0] value_q
);

  logic [31:0] lane_mask;
  logic [31:0] value_d;

  assign lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & WMASK;
  // bits outside WMASK never store, so software sizes the window by writing ones
  assign value_d   = (value_q & ~lane_mask) | (wdata & lane_mask) | FIXED;  // [R12] [R14]

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      value_q <= FIXED;  // [R23]
    end else if (wr_en) begin
      value_q <= value_d;
    end
  end

endmodule // window_base_reg

// file: verilog/bus_tenure_timer.sv
`timescale 1ns/1ns
// counts clocks of bus ownership and flags when the granted tenure is spent
module bus_tenure_timer (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [7:0] limit,
  input  wire logic       master_owns_bus,
  output logic            expired_q
);

  logic [7:0] count_q;
  logic [7:0] count_d;
  logic       at_limit;

  assign at_limit = (count_q >= limit);
  assign count_d  = at_limit ? count_q : count_q + 8'h01;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      count_q   <= 8'h00;
      expired_q <= 1'b0;
    end else if (master_owns_bus) begin
      count_q   <= count_d;
      expired_q <= at_limit;  // [R9]
    end else begin
      count_q   <= 8'h00;
      expired_q <= 1'b0;
    end
  end

endmodule // bus_tenure_timer

// file: verilog/pci_config_header_regs.sv
`timescale 1ns/1ns
// How it works
// R1 - revision is eight-bit read-only stepping code
// R2 - eeprom may replace revision low three bits
// R3 - load only if signature 01b and bit13
// R4 - class code reads 02h, 00h, 00h
// R5 - only 8/16 accepted, else no mwi
// R6 - unsupported cache line write reads zero
// R7 - bit3 only from 08h, bit4 from 10h
// R8 - firmware programs cache line, driver doesn't
// R9 - latency timer limits bus ownership clocks
// R10 - header type 00h single, 80h combo
// R11 - second function bank sits at 100h
// R12 - base bit0 reads memory 0, io 1
// R13 - io base bit0 one, bit1 zero
// R14 - only window-size upper bits writable
// R15 - csr memory window 4k, non-prefetchable
// R16 - csr io window is 64 bytes
// R17 - flash window always claims 128k
// R18 - cardbus cis served 64k above base
// R19 - rom window 1m, zero if boot-disabled
// R20 - modem select low after first rom access
// R21 - card_info_pointer zero pci, 00010003h cardbus
// R22 - retry config cycles until eeprom loaded
// R23 - writable fields clear on hardware reset
module pci_config_header_regs import cfg_hdr_pkg::*; #(
  parameter logic [7:0] REV_DEFAULT = 8'h05  // arbitrary stepping code
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        cardbus_mode,
  input  wire logic        ee_done,
  input  wire logic [15:0] ee_ctrl_word,
  input  wire logic        cfg_req,
  input  wire logic        cfg_we,
  input  wire logic [8:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  input  wire logic        bus_probe,
  input  wire logic        bus_is_io,
  input  wire logic [31:0] bus_addr,
  input  wire logic        master_owns_bus,
  output logic             cfg_ack_q,
  output logic             cfg_retry_q,
  output logic      [31:0] cfg_rdata_q,
  output logic             second_fn_req_q,
  output logic             mwi_allowed_q,
  output logic             tenure_expired_q,
  output logic             csr_mem_hit_q,
  output logic             csr_io_hit_q,
  output logic             flash_hit_q,
  output logic             cis_hit_q,
  output logic             rom_hit_q,
  output logic             modem_flash_select_n_q
);

  // ==========================================================
  // eeprom control word capture
  logic       ee_loaded_q;
  logic       rev_load_q;
  logic [2:0] rev_low_q;
  logic       combo_q;
  logic       boot_dis_q;
  logic       ee_take;
  logic       ee_sig_ok;

  assign ee_take   = ee_done && !ee_loaded_q;
  assign ee_sig_ok = (ee_ctrl_word[EE_SIG_HI:EE_SIG_LO] == EE_SIG_OK);

  // straps are caught on the clock after the automatic read, not in reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ee_loaded_q <= 1'b0;
      rev_load_q  <= 1'b0;
      rev_low_q   <= 3'b000;
      combo_q     <= 1'b0;
    end else if (ee_take) begin
      ee_loaded_q <= 1'b1;
      rev_load_q  <= ee_sig_ok && ee_ctrl_word[EE_ID_BIT];  // [R3]
      rev_low_q   <= ee_ctrl_word[EE_REV_HI:EE_REV_LO];
      combo_q     <= ee_sig_ok && ee_ctrl_word[EE_COMBO_BIT];
    end
  end

  // ==========================================================
  // identification fields
  logic [7:0] rev_id;
  logic [7:0] hdr_type;
  logic [31:0] cis_ptr;

  assign rev_id   = {REV_DEFAULT[7:3], rev_load_q ? rev_low_q : REV_DEFAULT[2:0]};  // [R1] [R2]
  assign hdr_type = combo_q ? HDR_COMBO : HDR_SINGLE;  // [R10]
  assign cis_ptr  = cardbus_mode ? CIS_PTR_CB : WORD_ZERO;  // [R21]

  // ==========================================================
  // configuration cycle decode
  logic [8:0] cfg_dw_addr;
  logic       fn_one;
  logic       cfg_go;
  logic       wr_go;
  logic       hit_misc;
  logic       hit_mem;
  logic       hit_io;
  logic       hit_flash;
  logic       hit_rom;
  logic       hit_rev;
  logic       hit_cis;

  assign cfg_dw_addr = {cfg_addr[8:2], 2'b00};
  assign fn_one      = cfg_addr[FN_SEL_BIT];
  assign cfg_go      = cfg_req && ee_loaded_q && !(fn_one && combo_q);
  assign wr_go       = cfg_go && cfg_we && !fn_one;
  assign hit_rev     = !fn_one && (cfg_dw_addr == OFS_REV_CLASS);
  assign hit_misc    = !fn_one && (cfg_dw_addr == OFS_MISC);
  assign hit_mem     = !fn_one && (cfg_dw_addr == OFS_BAR_MEM);
  assign hit_io      = !fn_one && (cfg_dw_addr == OFS_BAR_IO);
  assign hit_flash   = !fn_one && (cfg_dw_addr == OFS_BAR_FLASH);
  assign hit_cis     = !fn_one && (cfg_dw_addr == OFS_CIS_PTR);
  assign hit_rom     = !fn_one && (cfg_dw_addr == OFS_BAR_ROM);

  // ==========================================================
  // cache line size and latency timer
  logic [7:0] cls_q;
  logic [7:0] cls_d;
  logic [7:0] lat_q;
  logic       cls_wr;
  logic       lat_wr;

  assign cls_wr = wr_go && hit_misc && cfg_be[0];
  assign lat_wr = wr_go && hit_misc && cfg_be[1];
  // an unsupported size stores zero, which also switches mwi off
  assign cls_d  = (cfg_wdata[7:0] == CLS_8_DW)  ? CLS_8_DW  :
                  (cfg_wdata[7:0] == CLS_16_DW) ? CLS_16_DW : BYTE_ZERO;  // [R5] [R6] [R7]

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cls_q         <= BYTE_ZERO;  // [R23]
      lat_q         <= BYTE_ZERO;
      mwi_allowed_q <= 1'b0;
    end else begin
      if (cls_wr) begin
        cls_q <= cls_d;
      end
      if (lat_wr) begin
        lat_q <= cfg_wdata[15:8];
      end
      mwi_allowed_q <= (cls_q != BYTE_ZERO);  // [R5]
    end
  end

  bus_tenure_timer u_tenure (
    .mclk            (mclk),
    .rst_b           (rst_b),
    .limit           (lat_q),
    .master_owns_bus (master_owns_bus),
    .expired_q       (tenure_expired_q)
  );  // [R9]

  // ==========================================================
  // base address registers
  logic [31:0] bar_mem_q;
  logic [31:0] bar_io_q;
  logic [31:0] bar_flash_q;
  logic [31:0] bar_rom_q;

  window_base_reg #(.WMASK(MEM_MASK), .FIXED(TYPE_MEM)) u_bar_mem (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .wr_en   (wr_go && hit_mem),
    .be      (cfg_be),
    .wdata   (cfg_wdata),
    .value_q (bar_mem_q)
  );  // [R15]

  window_base_reg #(.WMASK(IO_MASK), .FIXED(TYPE_IO)) u_bar_io (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .wr_en   (wr_go && hit_io),
    .be      (cfg_be),
    .wdata   (cfg_wdata),
    .value_q (bar_io_q)
  );  // [R13] [R16]

  window_base_reg #(.WMASK(FLASH_MASK), .FIXED(TYPE_MEM)) u_bar_flash (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .wr_en   (wr_go && hit_flash),
    .be      (cfg_be),
    .wdata   (cfg_wdata),
    .value_q (bar_flash_q)
  );  // [R17]

  window_base_reg #(.WMASK(ROM_MASK), .FIXED(TYPE_MEM)) u_bar_rom (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .wr_en   (wr_go && hit_rom && !boot_dis_q),
    .be      (cfg_be),
    .wdata   (cfg_wdata),
    .value_q (bar_rom_q)
  );

  // ==========================================================
  // boot rom disable and modem flash select
  logic        rom_en;
  logic        rom_seen_q;
  logic        rom_claim;
  logic        sel_n_d;
  logic [31:0] rom_mask_addr;

  // the enable bit lives in the register but is no address bit, so it stays out of the compare
  assign rom_mask_addr = ROM_MASK & ~TYPE_IO;
  assign rom_en    = bar_rom_q[ROM_EN_BIT] && !boot_dis_q;
  assign rom_claim = bus_probe && !bus_is_io && rom_en &&
                     ((bus_addr & rom_mask_addr) == (bar_rom_q & rom_mask_addr));  // [R19]
  // the select stays high only until the boot code has had its first fetch
  assign sel_n_d   = combo_q && !boot_dis_q && rom_en && !rom_seen_q;  // [R20]

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      boot_dis_q             <= 1'b0;
      rom_seen_q             <= 1'b0;
      modem_flash_select_n_q <= 1'b1;
    end else begin
      if (ee_take) begin
        boot_dis_q <= ee_sig_ok && ee_ctrl_word[EE_BOOTDIS];
      end else if (rom_claim) begin
        boot_dis_q <= 1'b0;  // [R20]
      end
      if (rom_claim) begin
        rom_seen_q <= 1'b1;
      end
      modem_flash_select_n_q <= sel_n_d;
    end
  end

  // ==========================================================
  // address claims on the target side
  logic        mem_claim;
  logic        io_claim;
  logic        flash_claim;

  assign mem_claim   = bus_probe && !bus_is_io &&
                       ((bus_addr & MEM_MASK) == (bar_mem_q & MEM_MASK));  // [R15]
  assign io_claim    = bus_probe && bus_is_io &&
                       ((bus_addr & IO_MASK) == (bar_io_q & IO_MASK));  // [R16]
  // flash is claimed whether or not a part is fitted
  assign flash_claim = bus_probe && !bus_is_io &&
                       ((bus_addr & FLASH_MASK) == (bar_flash_q & FLASH_MASK));  // [R17]

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      csr_mem_hit_q <= 1'b0;
      csr_io_hit_q  <= 1'b0;
      flash_hit_q   <= 1'b0;
      cis_hit_q     <= 1'b0;
      rom_hit_q     <= 1'b0;
    end else begin
      csr_mem_hit_q <= mem_claim;
      csr_io_hit_q  <= io_claim;
      flash_hit_q   <= flash_claim && !(cardbus_mode && bus_addr[CIS_OFS_BIT]);
      cis_hit_q     <= flash_claim && cardbus_mode && bus_addr[CIS_OFS_BIT];  // [R18]
      rom_hit_q     <= rom_claim;
    end
  end

  // ==========================================================
  // read data and answer
  logic [31:0] rd_mux;
  logic [31:0] rom_read;

  assign rom_read = boot_dis_q ? WORD_ZERO : (bar_rom_q & rom_mask_addr | bar_rom_q);  // [R19]
  assign rd_mux   = hit_rev   ? {CLASS_CODE, rev_id} :  // [R4]
                    hit_misc  ? {BYTE_ZERO, hdr_type, lat_q, cls_q} :
                    hit_mem   ? bar_mem_q :
                    hit_io    ? bar_io_q :
                    hit_flash ? bar_flash_q :
                    hit_cis   ? cis_ptr :
                    hit_rom   ? rom_read : WORD_ZERO;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ack_q       <= 1'b0;
      cfg_retry_q     <= 1'b0;
      cfg_rdata_q     <= WORD_ZERO;
      second_fn_req_q <= 1'b0;
    end else begin
      cfg_ack_q       <= cfg_go;
      cfg_retry_q     <= cfg_req && !ee_loaded_q;  // [R22]
      cfg_rdata_q     <= (cfg_go && !cfg_we) ? rd_mux : WORD_ZERO;
      // in combo mode, function one at 100h is answered by the modem bank
      second_fn_req_q <= cfg_req && ee_loaded_q && fn_one && combo_q;  // [R11]
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_retry_early_cfg: assert property (  // [R22]
    cfg_req && !ee_loaded_q |=> cfg_retry_q && !cfg_ack_q)
    else $error("config cycle not retried before eeprom load");

  a_cls_only_legal: assert property (  // [R7]
    cls_q == BYTE_ZERO || cls_q == CLS_8_DW || cls_q == CLS_16_DW)
    else $error("cache line size holds illegal value");

  a_cls_bad_write: assert property (  // [R6]
    cls_wr && cfg_wdata[7:0] != CLS_8_DW && cfg_wdata[7:0] != CLS_16_DW
    |=> cls_q == BYTE_ZERO ##1 !mwi_allowed_q)
    else $error("bad cache line write not read as zero");

  a_class_read_val: assert property (  // [R4]
    cfg_go && !cfg_we && hit_rev |=> cfg_rdata_q[31:8] == CLASS_CODE)
    else $error("class code wrong");

  a_io_type_bits: assert property (  // [R13]
    bar_io_q[1:0] == 2'b01 && bar_mem_q[11:0] == 12'h000)
    else $error("base register low bits wrong");

  a_rom_boot_zero: assert property (  // [R19]
    cfg_go && !cfg_we && hit_rom && boot_dis_q |=> cfg_rdata_q == WORD_ZERO)
    else $error("boot disabled rom base not zero");

  a_cis_ptr_read: assert property (  // [R21]
    cfg_go && !cfg_we && hit_cis
    |=> cfg_rdata_q == ($past(cardbus_mode) ? CIS_PTR_CB : WORD_ZERO))
    else $error("card info pointer wrong");

  a_select_drops_low: assert property (  // [R20]
    rom_claim |=> ##1 !modem_flash_select_n_q)
    else $error("modem select not low after rom access");

  a_rev_low_load: assert property (  // [R3]
    ee_take && ee_sig_ok && ee_ctrl_word[EE_ID_BIT]
    |=> rev_id[2:0] == $past(ee_ctrl_word[EE_REV_HI:EE_REV_LO]))
    else $error("revision low bits not loaded");

endmodule // pci_config_header_regs

// file: sim/cfg_host_model.sv
`timescale 1ns/1ns
// ==========
// host bridge issuing configuration cycles
module cfg_host_model (
  input  wire logic        mclk,
  input  wire logic        ack,
  input  wire logic        retry,
  input  wire logic        fwd,
  input  wire logic [31:0] rdata,
  output logic             req,
  output logic             we,
  output logic [8:0]       addr,
  output logic [3:0]       be,
  output logic [31:0]      wdata
);
  initial begin
    req = 1'b0;
    we = 1'b0;
    addr = '0;
    be = '0;
    wdata = '0;
  end
  // gap gives a slow bridge; boot firmware writes cache line size through here
  // released lines are inverted so stale values never look valid
  task automatic access(input logic w, input logic [8:0] a, input logic [3:0] b,
                        input logic [31:0] d, input int gap, output logic [31:0] q,
                        output logic [2:0] resp);
    repeat (gap + 1) @(negedge mclk);
    req = 1'b1;
    we = w;
    addr = a;
    be = b;
    wdata = d;
    @(negedge mclk);
    q = rdata;
    resp = {ack, retry, fwd};
    req = 1'b0;
    we = ~w;
    addr = ~a;
    be = ~b;
    wdata = ~d;
  endtask
endmodule // cfg_host_model

// file: sim/tb_pci_config_header_regs.sv
`timescale 1ns/1ns
module tb_pci_config_header_regs import cfg_hdr_pkg::*;;
  localparam logic [7:0] REV_DEF = 8'h05; // arbitrary stepping code
  logic        mclk, rst_b, cardbus_mode, ee_done, bus_probe, bus_is_io, master_owns_bus;
  logic        cfg_req, cfg_we, ack, retry, fwd, mwi, expd, hm, hi, hf, hc, hr, msel;
  logic [15:0] ee_ctrl_word;
  logic [8:0]  cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, bus_addr, rdata, q, memb, iob, flb, romb;
  logic [2:0]  resp;
  logic [31:0] mdl[int];
  logic [7:0]  cls_tab[6] = '{8'h08, 8'h04, 8'h10, 8'hFF, 8'h18, 8'h10};
  logic [8:0]  bars[4] = '{OFS_BAR_MEM, OFS_BAR_IO, OFS_BAR_FLASH, OFS_BAR_ROM};
  int          err_total, checked, lim, n;
  bit          combo, bootdis;

  pci_config_header_regs #(.REV_DEFAULT(REV_DEF)) u_dut (
    .mclk(mclk), .rst_b(rst_b), .cardbus_mode(cardbus_mode), .ee_done(ee_done),
    .ee_ctrl_word(ee_ctrl_word), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .bus_probe(bus_probe), .bus_is_io(bus_is_io),
    .bus_addr(bus_addr), .master_owns_bus(master_owns_bus), .cfg_ack_q(ack),
    .cfg_retry_q(retry), .cfg_rdata_q(rdata), .second_fn_req_q(fwd), .mwi_allowed_q(mwi),
    .tenure_expired_q(expd), .csr_mem_hit_q(hm), .csr_io_hit_q(hi), .flash_hit_q(hf),
    .cis_hit_q(hc), .rom_hit_q(hr), .modem_flash_select_n_q(msel));
  cfg_host_model u_host (
    .mclk(mclk), .ack(ack), .retry(retry), .fwd(fwd), .rdata(rdata), .req(cfg_req),
    .we(cfg_we), .addr(cfg_addr), .be(cfg_be), .wdata(cfg_wdata));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ==========
  // shared tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [8:0] a, input logic [3:0] b, input logic [31:0] d);
    logic [31:0] m, wm;
    m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    wm = (a == OFS_BAR_MEM) ? MEM_MASK : (a == OFS_BAR_IO) ? IO_MASK :
         (a == OFS_BAR_FLASH) ? FLASH_MASK : (a == OFS_BAR_ROM && !bootdis) ? ROM_MASK :
         (a == OFS_MISC) ? 32'h0000_FF00 : WORD_ZERO;
    u_host.access(1'b1, a, b, d, $urandom_range(2), q, resp);
    check("write answer", 32'(resp), 32'h0000_0004);
    if (mdl.exists(a)) mdl[a] = (mdl[a] & ~(m & wm)) | (d & m & wm);
    if (a == OFS_MISC && b[0])
      mdl[a][7:0] = (d[7:0] == CLS_8_DW || d[7:0] == CLS_16_DW) ? d[7:0] : BYTE_ZERO;
  endtask
  task automatic rd(input logic [8:0] a, input string nm);
    u_host.access(1'b0, a, 4'hF, $urandom, $urandom_range(2), q, resp);
    check(nm, q, mdl.exists(a) ? mdl[a] : WORD_ZERO);
    check("read answer", 32'(resp), (a[FN_SEL_BIT] && combo) ? 32'h0000_0001 : 32'h0000_0004);
  endtask
  task automatic probe(input logic io, input logic [31:0] ad, input logic [4:0] e,
                       input string nm);
    @(negedge mclk);
    bus_probe = 1'b1;
    bus_is_io = io;
    bus_addr = ad;
    @(negedge mclk);
    bus_probe = 1'b0;
    bus_is_io = ~io;
    bus_addr = ~ad;
    check(nm, 32'({hm, hi, hf, hc, hr}), 32'(e));
  endtask
  task automatic do_reset(input logic [15:0] ee);
    logic ok;
    rst_b = 1'b0;
    ee_done = 1'b0;
    ee_ctrl_word = ee;
    repeat (20) @(negedge mclk);
    rst_b = 1'b1;
    ok = ee[EE_SIG_HI:EE_SIG_LO] == EE_SIG_OK;
    combo = ok && ee[EE_COMBO_BIT];
    bootdis = ok && ee[EE_BOOTDIS];
    mdl.delete();
    mdl[OFS_REV_CLASS] = {CLASS_CODE, REV_DEF[7:3],
                          (ok && ee[EE_ID_BIT]) ? ee[EE_REV_HI:EE_REV_LO] : REV_DEF[2:0]};
    mdl[OFS_MISC] = {8'h00, combo ? HDR_COMBO : HDR_SINGLE, 16'h0000};
    mdl[OFS_BAR_MEM] = TYPE_MEM;
    mdl[OFS_BAR_IO] = TYPE_IO;
    mdl[OFS_BAR_FLASH] = TYPE_MEM;
    mdl[OFS_BAR_ROM] = WORD_ZERO;
    mdl[OFS_CIS_PTR] = WORD_ZERO;
    u_host.access(1'b0, OFS_REV_CLASS, 4'hF, 32'h0000_0000, 0, q, resp);
    check("early answer", 32'(resp), 32'h0000_0002);
    ee_done = 1'b1;
    repeat (2) @(negedge mclk);
  endtask

  // ==========
  // tests
  initial begin
    #(4 * 30000);
    err_total++;
    print_verdict;
  end
  initial begin
    n = $urandom(32'h4ea061f9);
    {cardbus_mode, bus_probe, bus_is_io, master_owns_bus} = 4'h0;
    bus_addr = 32'h0000_0000;
    do_reset(16'h7600);
    rd(OFS_REV_CLASS, "rev class");
    rd(OFS_MISC, "misc after reset");
    rd(OFS_CIS_PTR, "cis ptr pci");
    $display("test identity done");
    foreach (cls_tab[i]) begin
      wr(OFS_MISC, 4'h1, {24'($urandom), cls_tab[i]});
      rd(OFS_MISC, "cache line");
      check("mwi", 32'(mwi), 32'(mdl[OFS_MISC][7:0] != BYTE_ZERO));
    end
    lim = $urandom_range(20, 4);
    wr(OFS_MISC, 4'h2, {16'h0000, 8'(lim), 8'h00});
    rd(OFS_MISC, "latency");
    master_owns_bus = 1'b1;
    n = 0;
    while (expd !== 1'b1 && n < 300) begin
      @(negedge mclk);
      n++;
    end
    check("tenure", 32'(n >= lim && n <= lim + 2), 32'h0000_0001);
    master_owns_bus = 1'b0;
    repeat (2) @(negedge mclk);
    check("tenure clear", 32'(expd), 32'h0000_0000);
    $display("test cache line and latency done");
    foreach (bars[i]) begin
      wr(bars[i], 4'hF, 32'hFFFF_FFFF);
      rd(bars[i], "bar size");
    end
    check("select armed", 32'(msel), 32'h0000_0001);
    memb = {8'h10, 24'($urandom)} & MEM_MASK;
    iob = {1'b0, 31'($urandom)} & IO_MASK;
    flb = {8'h20, 24'($urandom)} & FLASH_MASK;
    romb = ({8'h30, 24'($urandom)} & ROM_MASK) | 32'h0000_0001;
    wr(OFS_BAR_MEM, 4'hF, memb);
    wr(OFS_BAR_IO, 4'hF, iob);
    wr(OFS_BAR_FLASH, 4'hF, flb);
    wr(OFS_BAR_ROM, 4'hF, romb);
    probe(1'b0, memb + 32'h0000_0FFC, 5'b10000, "mem hit");
    probe(1'b0, memb + 32'h0000_1000, 5'b00000, "mem edge");
    probe(1'b1, iob + 32'h0000_003F, 5'b01000, "io hit");
    probe(1'b1, iob + 32'h0000_0040, 5'b00000, "io edge");
    probe(1'b0, flb + 32'h0001_FFFC, 5'b00100, "flash pci");
    cardbus_mode = 1'b1;
    probe(1'b0, flb + 32'h0000_0100, 5'b00100, "flash cardbus");
    probe(1'b0, flb + 32'h0001_0000, 5'b00010, "cis window");
    mdl[OFS_CIS_PTR] = CIS_PTR_CB;
    rd(OFS_CIS_PTR, "cis ptr cardbus");
    cardbus_mode = 1'b0;
    mdl[OFS_CIS_PTR] = WORD_ZERO;
    rd(9'h108, "second fn");
    probe(1'b0, (romb & 32'hFFF0_0000) | 32'h000F_FFF0, 5'b00001, "rom hit");
    repeat (2) @(negedge mclk);
    check("select after rom", 32'(msel), 32'h0000_0000);
    $display("test windows done");
    do_reset(16'h4800);
    wr(OFS_BAR_ROM, 4'hF, 32'hFFFF_FFFF);
    rd(OFS_BAR_ROM, "rom disabled");
    rd(OFS_MISC, "single header");
    do_reset(16'hF700);
    rd(OFS_REV_CLASS, "rev default");
    rd(9'h108, "fn1 single");
    rd(9'h0F0, "unmapped");
    $display("test eeprom variants done");
    print_verdict;
  end
endmodule // tb_pci_config_header_regs
